// *** inc/mtpas_defines.svh ***
// Constants for the multi-lane transmit phase alignment sequencer
`ifndef MTPAS_DEFINES_SVH
`define MTPAS_DEFINES_SVH
`define MTPAS_CLK_PERIOD_NS      100
`define MTPAS_SRST_DONE_MIN_NS   100
`define MTPAS_SRST_DONE_MIN_CYC  ((`MTPAS_SRST_DONE_MIN_NS + `MTPAS_CLK_PERIOD_NS - 1) / `MTPAS_CLK_PERIOD_NS)
`define MTPAS_OUTCLK_SEL_REF0    3'h3
`define MTPAS_OUTCLK_SEL_REF1    3'h4
`define MTPAS_OUTCLK_SEL_REF2    3'h5
`define MTPAS_ADDR_CTRL          12'h000
`define MTPAS_ADDR_STATUS        12'h004
`define MTPAS_ADDR_CFG           12'h008
`define MTPAS_CTRL_START_BIT     0
`define MTPAS_CTRL_AUTO_BIT      1
`define MTPAS_CTRL_RXGO_BIT      2
`define MTPAS_CFG_OCS_LSB        0
`define MTPAS_CFG_RESET_VAL      32'h0000_0003
`define MTPAS_ST_BUSY_BIT        0
`define MTPAS_ST_DONE_BIT        1
`define MTPAS_ST_ALIGNED_BIT     2
`define MTPAS_ST_RXEN_BIT        3
`define MTPAS_ST_STATE_LSB       8
`endif

// *** inc/mtpas_pkg.sv ***
// Types for the multi-lane transmit phase alignment sequencer
package mtpas_pkg;
    typedef enum logic [10:0] {
        MTPAS_IDLE    = 11'h001,
        MTPAS_SRST    = 11'h002,
        MTPAS_M_INIT  = 11'h004,
        MTPAS_M_ALIGN = 11'h008,
        MTPAS_M_DLY1  = 11'h010,
        MTPAS_S_INIT  = 11'h020,
        MTPAS_S_ALIGN = 11'h040,
        MTPAS_M_DLY2  = 11'h080,
        MTPAS_A_SRST  = 11'h100,
        MTPAS_A_WAIT  = 11'h200,
        MTPAS_DONE    = 11'h400
    } mtpas_state_t;
endpackage : mtpas_pkg

// *** verif/mtpas_lane_model.sv ***
// Behavioural group of transceiver lanes answering the sequencer's alignment requests
`timescale 1ns/1ns
module mtpas_lane_model #(
    parameter int N      = 4,
    parameter int MASTER = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         auto_en,
    input  wire logic [7:0]   lat,
    input  wire logic [N-1:0] srst_req,
    input  wire logic [N-1:0] init_req,
    input  wire logic [N-1:0] align_req,
    input  wire logic [N-1:0] dly_en,
    output logic      [N-1:0] srst_done,
    output logic      [N-1:0] init_done,
    output logic      [N-1:0] align_done,
    output logic              sync_done
);
    logic [N-1:0]      srst_p, init_p, align_p, dly_p;
    logic [N-1:0][7:0] cs, ci, ca;
    logic [9:0]        cy;
    // Latency comes from the bench so the same model answers both promptly and slowly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {srst_p, init_p, align_p, dly_p, srst_done, init_done, align_done} <= '0;
            {cs, ci, ca} <= '0;
        end else begin
            {srst_p, init_p, align_p, dly_p} <= {srst_req, init_req, align_req, dly_en};
            for (int i = 0; i < N; i++) begin
                if (srst_req[i]) begin
                    cs[i] <= (cs[i] == 8'hff) ? cs[i] : cs[i] + 8'h01;
                    srst_done[i] <= (cs[i] >= lat);
                end else begin
                    cs[i] <= '0;
                    srst_done[i] <= srst_done[i] & (cs[i] != 8'h00);
                end
                if (init_req[i] & ~init_p[i]) begin
                    init_done[i] <= 1'b0;
                    ci[i] <= lat;
                end else if (ci[i] == 8'h01) begin
                    init_done[i] <= 1'b1;
                    ci[i] <= '0;
                end else if (ci[i] != 8'h00) begin
                    ci[i] <= ci[i] - 8'h01;
                end
                if ((align_req[i] & ~align_p[i]) | (dly_en[i] & ~dly_p[i])) begin
                    align_done[i] <= 1'b0;
                    ca[i] <= lat;
                end else if (ca[i] == 8'h01) begin
                    align_done[i] <= 1'b1;
                    ca[i] <= '0;
                end else if (ca[i] != 8'h00) begin
                    ca[i] <= ca[i] - 8'h01;
                end
            end
            if (auto_en && cy == 10'h001)
                align_done[MASTER] <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_done <= 1'b0;
            cy <= '0;
        end else if (|(srst_req & ~srst_p)) begin
            sync_done <= 1'b0;
            cy <= auto_en ? {lat, 2'b00} : 10'h000;
        end else if (cy == 10'h001) begin
            sync_done <= 1'b1;
            cy <= '0;
        end else if (cy != 10'h000) begin
            cy <= cy - 10'h001;
        end
    end
endmodule : mtpas_lane_model

// *** verif/mtpas_seq_tb_top.sv ***
// Self-checking bench for the multi-lane transmit phase alignment sequencer
`timescale 1ns/1ns
`include "mtpas_defines.svh"
module mtpas_seq_tb_top;
    localparam int           N   = 4;
    localparam int           M   = 1;
    localparam logic [N-1:0] MB  = N'(1) << M;
    localparam logic [N-1:0] SLV = ~MB;
    localparam logic [N-1:0] ALL = '1;
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic              realign_event = 1'b0, auto_m = 1'b0, err;
    logic [11:0]       paddr = '0;
    logic [31:0]       pwdata = '0, prdata, rd;
    logic [7:0]        lat = 8'h04;
    logic [2:0]        out_clock_select;
    logic              pready, pslverr, sync_override_attr, multilane_sync_attr, tx_buffer_enable_attr;
    logic              internal_clock_select_attr, rx_align_start, auto_sync_done;
    logic [N-1:0]      delay_soft_reset_done, phase_init_done, phase_align_done, phase_delay_reset_in;
    logic [N-1:0]      delay_bypass_in, phase_align_enable_in, delay_soft_reset_req, phase_init_req;
    logic [N-1:0]      phase_align_req, delay_align_enable, rx_skip_delay_align_attr;
    logic [N-1:0]      p_srst = '0, p_init = '0, p_align = '0;
    int                n_mismatch = 0, comparisons = 0, cyc = 0;
    always #50 pclk = ~pclk;
    mtpas_seq #(.NLANES(N), .MASTER(M)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .realign_event, .delay_soft_reset_done, .phase_init_done, .phase_align_done, .auto_sync_done,
        .phase_delay_reset_in, .delay_bypass_in, .phase_align_enable_in, .delay_soft_reset_req,
        .phase_init_req, .phase_align_req, .delay_align_enable, .sync_override_attr, .multilane_sync_attr,
        .rx_skip_delay_align_attr, .tx_buffer_enable_attr, .internal_clock_select_attr, .out_clock_select,
        .rx_align_start);
    mtpas_lane_model #(.N(N), .MASTER(M)) lanes (
        .clk(pclk), .rstn(presetn), .auto_en(auto_m), .lat, .srst_req(delay_soft_reset_req),
        .init_req(phase_init_req), .align_req(phase_align_req), .dly_en(delay_align_enable),
        .srst_done(delay_soft_reset_done), .init_done(phase_init_done), .align_done(phase_align_done),
        .sync_done(auto_sync_done));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: value %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Ends one edge after release so the next setup never reassigns psel in the same step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_done;
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, `MTPAS_ADDR_STATUS, 32'h0);
            if (rd[`MTPAS_ST_DONE_BIT] === 1'b1) break;
        end
    endtask : wait_done
    task automatic run(input logic am, input logic rxgo);
        auto_m <= am;
        apb(1'b1, `MTPAS_ADDR_CTRL, {29'h0, rxgo, am, 1'b1});
        repeat (4) @(posedge pclk);
        apb(1'b0, `MTPAS_ADDR_STATUS, 32'h0);
        chk(rd[`MTPAS_ST_BUSY_BIT], 1'b1);
        chk(rx_align_start, 1'b0);
        chk({multilane_sync_attr, sync_override_attr}, {am, ~am});
        wait_done();
        chk(rd[`MTPAS_ST_DONE_BIT], 1'b1);
        chk(rd[`MTPAS_ST_ALIGNED_BIT], 1'b1);
        chk(rd[`MTPAS_ST_RXEN_BIT], rxgo);
        chk(delay_soft_reset_req | phase_init_req | phase_align_req, '0);
        chk(rx_align_start, rxgo);
    endtask : run
    // Order monitor; reads pre-edge values so it never races the design's updates
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            chk(|(p_srst & ~delay_soft_reset_req & ~delay_soft_reset_done), 1'b0);
            chk(|(p_init & ~phase_init_req & ~phase_init_done), 1'b0);
            chk(|(p_align & ~phase_align_req & ~phase_align_done), 1'b0);
            chk(phase_init_req[M] & |delay_soft_reset_req, 1'b0);
            chk(|(phase_init_req & SLV) & delay_align_enable[M], 1'b0);
            chk(|(phase_align_req & SLV) & |(phase_init_req & SLV), 1'b0);
            chk(delay_align_enable & SLV, '0);
            chk(auto_m & |(phase_init_req | phase_align_req), 1'b0);
            if (|(delay_soft_reset_req & ~p_srst)) chk(delay_soft_reset_req, ALL);
            if (|(phase_init_req & ~p_init & SLV)) chk(phase_init_req & SLV, SLV);
            if (|(phase_align_req & ~p_align & SLV)) chk(phase_align_req & SLV, SLV);
        end
        p_srst  = delay_soft_reset_req;
        p_init  = phase_init_req;
        p_align = phase_align_req;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(out_clock_select, 3'h3);
        chk({tx_buffer_enable_attr, internal_clock_select_attr}, 2'b01);
        chk(phase_delay_reset_in | delay_bypass_in, '0);
        chk(phase_align_enable_in, ALL);
        chk(rx_skip_delay_align_attr, ALL);
        apb(1'b0, `MTPAS_ADDR_CFG, 32'h0);
        chk(rd, `MTPAS_CFG_RESET_VAL);
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, `MTPAS_ADDR_CFG, 32'(v));
            chk(out_clock_select, (v >= 3 && v <= 5) ? 3'(v) : 3'h3);
        end
        apb(1'b0, 12'hffc, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        run(1'b0, 1'b0);
        chk(delay_align_enable, MB);
        lat <= 8'h0c;
        run(1'b0, 1'b1);
        chk(delay_align_enable, MB);
        lat <= 8'h04;
        run(1'b1, 1'b0);
        realign_event <= 1'b1;
        @(posedge pclk);
        realign_event <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(delay_soft_reset_req, ALL);
        wait_done();
        chk(rd[`MTPAS_ST_DONE_BIT], 1'b1);
        give_verdict();
    end
endmodule : mtpas_seq_tb_top

// *** verilog/mtpas_apb_regs.sv ***
// APB slave holding control and configuration words and reading back the status word
`timescale 1ns/1ns
`include "mtpas_defines.svh"
module mtpas_apb_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] status,
    output logic             start_pulse,
    output logic             auto_mode,
    output logic             rx_go,
    output logic      [2:0]  out_sel
);
    logic        wr;
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic        start_q;
    logic        unmapped;

    assign wr       = psel & penable & pwrite;
    assign unmapped = (paddr != `MTPAS_ADDR_CTRL) && (paddr != `MTPAS_ADDR_STATUS) && (paddr != `MTPAS_ADDR_CFG);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & unmapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= 32'h0;
            cfg_q   <= `MTPAS_CFG_RESET_VAL;
            start_q <= 1'b0;
        end else begin
            start_q <= wr && paddr == `MTPAS_ADDR_CTRL && pwdata[`MTPAS_CTRL_START_BIT];
            if (wr && paddr == `MTPAS_ADDR_CTRL) begin
                ctrl_q <= pwdata & 32'h0000_0006;
            end
            if (wr && paddr == `MTPAS_ADDR_CFG) begin
                cfg_q <= pwdata & 32'h0000_0007;
            end
        end
    end

    always_comb begin
        unique case (paddr)
            `MTPAS_ADDR_CTRL:   prdata = ctrl_q;
            `MTPAS_ADDR_STATUS: prdata = status;
            `MTPAS_ADDR_CFG:    prdata = cfg_q;
            default:            prdata = 32'h0;
        endcase
    end

    assign start_pulse = start_q;
    assign auto_mode   = ctrl_q[`MTPAS_CTRL_AUTO_BIT];
    assign rx_go       = ctrl_q[`MTPAS_CTRL_RXGO_BIT];
    // Illegal codes fall back to the first reference-clock select
    assign out_sel     = (cfg_q[2:0] == `MTPAS_OUTCLK_SEL_REF1 || cfg_q[2:0] == `MTPAS_OUTCLK_SEL_REF2)
                         ? cfg_q[2:0] : `MTPAS_OUTCLK_SEL_REF0;
endmodule : mtpas_apb_regs

// *** verilog/mtpas_seq.sv ***
// Fabric controller sequencing multi-lane transmit phase and delay alignment
`timescale 1ns/1ns
`include "mtpas_defines.svh"
module mtpas_seq
    import mtpas_pkg::*;
#(
    parameter int NLANES = 4,
    parameter int MASTER = 1
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              realign_event,
    input  wire logic [NLANES-1:0] delay_soft_reset_done,
    input  wire logic [NLANES-1:0] phase_init_done,
    input  wire logic [NLANES-1:0] phase_align_done,
    input  wire logic              auto_sync_done,
    output logic      [NLANES-1:0] phase_delay_reset_in,
    output logic      [NLANES-1:0] delay_bypass_in,
    output logic      [NLANES-1:0] phase_align_enable_in,
    output logic      [NLANES-1:0] delay_soft_reset_req,
    output logic      [NLANES-1:0] phase_init_req,
    output logic      [NLANES-1:0] phase_align_req,
    output logic      [NLANES-1:0] delay_align_enable,
    output logic                   sync_override_attr,
    output logic                   multilane_sync_attr,
    output logic      [NLANES-1:0] rx_skip_delay_align_attr,
    output logic                   tx_buffer_enable_attr,
    output logic                   internal_clock_select_attr,
    output logic      [2:0]        out_clock_select,
    output logic                   rx_align_start
);
    localparam logic [NLANES-1:0] M_MASK = NLANES'(1) << MASTER;
    localparam logic [NLANES-1:0] S_MASK = ~M_MASK;

    mtpas_state_t      state_q;
    logic [NLANES-1:0] srst_q;
    logic [NLANES-1:0] init_q;
    logic [NLANES-1:0] align_q;
    logic              dly_q;
    logic              done_q;
    logic              rx_start_q;
    logic              auto_q;
    logic              start_pulse;
    logic              auto_mode;
    logic              rx_go;
    logic [2:0]        out_sel;
    logic [31:0]       status;
    logic [NLANES-1:0] srst_lvl;
    logic [NLANES-1:0] init_rise;
    logic [NLANES-1:0] align_lvl;
    logic [NLANES-1:0] align_rise;
    logic              sync_lvl;
    logic              go;

    function automatic logic all_clear(input logic [NLANES-1:0] v, input logic [NLANES-1:0] m);
        all_clear = ((v & m) == '0);
    endfunction : all_clear

    mtpas_apb_regs u_regs (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .status      (status),
        .start_pulse (start_pulse),
        .auto_mode   (auto_mode),
        .rx_go       (rx_go),
        .out_sel     (out_sel)
    );

    // Done flags arrive from the lane clock domain
    mtpas_sync_edge #(.W(NLANES)) u_srst_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (delay_soft_reset_done),
        .level    (srst_lvl),
        .rise     ()
    );
    mtpas_sync_edge #(.W(NLANES)) u_init_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (phase_init_done),
        .level    (),
        .rise     (init_rise)
    );
    mtpas_sync_edge #(.W(NLANES)) u_align_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (phase_align_done),
        .level    (align_lvl),
        .rise     (align_rise)
    );
    mtpas_sync_edge #(.W(1)) u_sdone_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (auto_sync_done),
        .level    (sync_lvl),
        .rise     ()
    );

    // Any realign event restarts the whole procedure, even mid-sequence
    assign go = start_pulse | realign_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MTPAS_IDLE;
            srst_q  <= '0;
            init_q  <= '0;
            align_q <= '0;
            dly_q   <= 1'b0;
            done_q  <= 1'b0;
            auto_q  <= 1'b0;
        end else if (go) begin
            auto_q  <= auto_mode;
            srst_q  <= '1;
            init_q  <= '0;
            align_q <= '0;
            dly_q   <= 1'b0;
            done_q  <= 1'b0;
            state_q <= auto_mode ? MTPAS_A_SRST : MTPAS_SRST;
        end else begin
            unique case (state_q)
                MTPAS_IDLE, MTPAS_DONE: begin
                end
                MTPAS_SRST: begin
                    srst_q <= srst_q & ~srst_lvl;
                    if (all_clear(srst_q, '1)) begin
                        init_q  <= M_MASK;
                        state_q <= MTPAS_M_INIT;
                    end
                end
                MTPAS_M_INIT: begin
                    // A stale high init-done shows no rise until the lane drops it
                    if (init_rise[MASTER]) begin
                        init_q  <= '0;
                        align_q <= M_MASK;
                        state_q <= MTPAS_M_ALIGN;
                    end
                end
                MTPAS_M_ALIGN: begin
                    if (align_rise[MASTER]) begin
                        align_q <= '0;
                        dly_q   <= 1'b1;
                        state_q <= MTPAS_M_DLY1;
                    end
                end
                MTPAS_M_DLY1: begin
                    // Align-done first falls, so its next rise marks delay settle
                    if (align_rise[MASTER]) begin
                        dly_q   <= 1'b0;
                        init_q  <= S_MASK;
                        state_q <= MTPAS_S_INIT;
                    end
                end
                MTPAS_S_INIT: begin
                    init_q <= init_q & ~init_rise;
                    if (all_clear(init_q, S_MASK)) begin
                        align_q <= S_MASK;
                        state_q <= MTPAS_S_ALIGN;
                    end
                end
                MTPAS_S_ALIGN: begin
                    align_q <= align_q & ~align_rise;
                    if (all_clear(align_q, S_MASK)) begin
                        dly_q   <= 1'b1;
                        state_q <= MTPAS_M_DLY2;
                    end
                end
                MTPAS_M_DLY2: begin
                    if (align_rise[MASTER]) begin
                        done_q  <= 1'b1;
                        state_q <= MTPAS_DONE;
                    end
                end
                MTPAS_A_SRST: begin
                    srst_q <= srst_q & ~srst_lvl;
                    if (all_clear(srst_q, '1)) begin
                        state_q <= MTPAS_A_WAIT;
                    end
                end
                MTPAS_A_WAIT: begin
                    // Sync-done stays high until the next start
                    if (sync_lvl) begin
                        done_q  <= 1'b1;
                        state_q <= MTPAS_DONE;
                    end
                end
                default: begin
                    state_q <= MTPAS_IDLE;
                end
            endcase
        end
    end

    // Receive alignment only after transmit alignment completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_start_q <= 1'b0;
        end else begin
            rx_start_q <= rx_go & done_q & ~go;
        end
    end

    assign phase_delay_reset_in  = '0;
    assign delay_bypass_in       = '0;
    assign phase_align_enable_in = '1;
    assign delay_soft_reset_req  = srst_q;
    assign phase_init_req        = init_q;
    assign phase_align_req       = align_q;
    // Only the master lane ever gets delay enable; slaves skip it
    assign delay_align_enable    = dly_q ? M_MASK : '0;
    assign rx_skip_delay_align_attr = '1;
    assign sync_override_attr    = ~auto_q;
    assign multilane_sync_attr   = auto_q;
    assign tx_buffer_enable_attr = 1'b0;
    assign internal_clock_select_attr = 1'b1;
    assign out_clock_select      = out_sel;
    assign rx_align_start        = rx_start_q;

    // Master align-done after completion reports held alignment in status
    assign status = {20'h0, state_q[3:0] | {1'b0, state_q[10:8]}, 4'h0,
                     rx_go & done_q, align_lvl[MASTER] & done_q, done_q,
                     ~state_q[0] & ~done_q};

    a_init_release: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MTPAS_M_INIT && init_rise[MASTER] && !go) |=> phase_init_req == '0 && phase_align_req == M_MASK)
        else $error("master init not released into align");
    a_srst_order: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_init_req != '0) |-> delay_soft_reset_req == '0)
        else $error("init raised while soft reset held");
    a_dly_off_slaves: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MTPAS_S_INIT || state_q == MTPAS_S_ALIGN) |-> delay_align_enable == '0)
        else $error("delay enable high during slave steps");
    a_slave_align_order: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_align_req & S_MASK) != '0 |-> (phase_init_req == '0))
        else $error("slave align overlaps init");
    a_dly_hold_done: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MTPAS_DONE && !auto_q && !go) |=> delay_align_enable == M_MASK)
        else $error("delay enable dropped after completion");
    a_rx_after_tx: assert property (@(posedge pclk) disable iff (!presetn)
        rx_align_start |-> $past(done_q))
        else $error("receive alignment before transmit done");
    a_no_slave_dly: assert property (@(posedge pclk) disable iff (!presetn)
        (delay_align_enable & S_MASK) == '0)
        else $error("slave given delay enable");
    a_start_srst: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> delay_soft_reset_req == '1 && phase_init_req == '0)
        else $error("start did not assert soft reset on all lanes");
endmodule : mtpas_seq

// *** verilog/mtpas_sync_edge.sv ***
// Two-stage synchroniser with rising-edge detect, one bit per lane
`timescale 1ns/1ns
module mtpas_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // Only sync_q reads meta_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
endmodule : mtpas_sync_edge
